// [tb/otg_pins_model.sv]
// partner model: transceiver line levels, id pin and vbus comparators
// assumes the bench steers cable, vbus and raw line levels after a clock edge
`timescale 1ns/1ps
`default_nettype none

module otg_pins_model (
  input  wire logic                 mclk,     // module clock
  input  wire logic                 cableA,   // type a cable inserted
  input  wire logic                 vbusOn,   // vbus above session valid
  input  wire logic [1:0]           lineRaw,  // raw d+ and d- levels
  output var  otg_event_pkg::pins_t pins      // comparator and line outputs
);
  // idle: no cable, no vbus, line in j
  initial pins = 8'ha4;

  // comparators follow one cycle later, levels kept mutually consistent
  always @(posedge mclk) begin
    pins.identPin   <= ~cableA;            // high with no cable or type b
    pins.sessValid  <= vbusOn;             // a or b device
    pins.sessEnd    <= ~vbusOn & ~cableA;  // only a b device reports end
    pins.aVbusValid <= vbusOn & cableA;    // only an a device
    pins.se0        <= 1'b0;               // line held idle so stability runs
    pins.line_j_indication     <= 1'b1;
    pins.dPlus      <= lineRaw[1];         // raw lines only wake the block
    pins.dMinus     <= lineRaw[0];
  end
endmodule
`default_nettype wire

// [tb/usb_otg_event_status_bench.sv]
// bench for the otg event block: integer model of flags, enables and status
// assumes the pin model beside it and the register offsets of the package
`timescale 1ns/1ps
`default_nettype none

module usb_otg_event_status_bench;
  logic                   mclk;      // 100 MHz
  logic                   rst;       // async, active high
  logic                   cableA;    // model steering
  logic                   vbusOn;
  logic [1:0]             lineRaw;
  otg_event_pkg::pins_t   pinsNow;   // model pins into design
  otg_event_pkg::pins_t   old;       // pins before a step
  otg_event_pkg::regreq_t req;       // register request
  logic [31:0]            rdata;
  logic                   otgIrq;
  logic [31:0]            v;         // read result
  logic [31:0]            r;         // random word
  logic [7:0]             expFlags;  // model of sticky flags
  logic [7:0]             expEn;     // model of enables
  logic [1:0]             step [6];  // cable and vbus per step
  int                     cyc;       // cycles since reset release
  int                     nMismatch;
  int                     cmpCount;

  otg_pins_model i_otg_pins_model (.mclk(mclk), .cableA(cableA), .vbusOn(vbusOn), .lineRaw(lineRaw), .pins(pinsNow));
  usb_otg_event_status i_usb_otg_event_status (.mclk(mclk), .rst(rst), .pinsIn(pinsNow), .regReq(req),
                                               .rdata(rdata), .otgIrq(otgIrq));

  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= rst ? 0 : cyc + 1;

  // ---------------------------------------------------------------
  // bus tasks and compare
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // events a pin step should raise
  function automatic logic [7:0] evt(otg_event_pkg::pins_t o, otg_event_pkg::pins_t n);
    logic wk;
    wk = |(o[7:6] ^ n[7:6]) | (o.aVbusValid ^ n.aVbusValid) | |(o[1:0] ^ n[1:0]);
    evt = {o.identPin ^ n.identPin, 2'b00, wk, ~o.sessEnd & n.sessEnd, o.sessEnd ^ n.sessEnd, 1'b0,
           o.sessValid ^ n.sessValid};
  endfunction

  function automatic logic [31:0] stat(input logic lineOk);
    stat = {24'h0, pinsNow.identPin, 1'b0, lineOk, 1'b0, pinsNow.sessValid, pinsNow.sessEnd, 1'b0,
            pinsNow.aVbusValid};
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: whole run is near 100100 cycles
  initial begin
    #1300000;
    nMismatch++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 0; rst = 1; req = '0; cableA = 0; vbusOn = 0; lineRaw = 2'b00; nMismatch = 0; cmpCount = 0;
    expFlags = 8'h00; expEn = 8'h00;
    step = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b01, 2'b00};
    void'($urandom(32'hd7d0));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(otg_event_pkg::OFS_EVENT_FLAGS, v);   chk("flags", v, 32'h0);
    rd(otg_event_pkg::OFS_EVENT_ENABLES, v); chk("enables", v, 32'h0);
    rd(otg_event_pkg::OFS_LIVE_STATUS, v);   chk("status", v, stat(1'b0));
    wr(otg_event_pkg::OFS_LIVE_STATUS, 32'hffffffff);
    rd(8'h0c, v); chk("unmapped", v, 32'h0);
    rd(otg_event_pkg::OFS_LIVE_STATUS, v);   chk("status", v, stat(1'b0));
    $display("test reset and map done");
    // each step moves cable or vbus and random raw lines
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      wr(otg_event_pkg::OFS_EVENT_ENABLES, r);
      expEn = r[7:0] & otg_event_pkg::IMPL_MASK;
      rd(otg_event_pkg::OFS_EVENT_ENABLES, v); chk("enables", v, {24'h0, expEn});
      old = pinsNow;
      {cableA, vbusOn} <= step[i];
      lineRaw <= 2'($urandom);
      repeat (8) @(posedge mclk);
      expFlags |= evt(old, pinsNow);
      rd(otg_event_pkg::OFS_EVENT_FLAGS, v); chk("flags", v, {24'h0, expFlags});
      chk("irq", {31'h0, otgIrq}, {31'h0, |(expFlags & expEn)});
      rd(otg_event_pkg::OFS_LIVE_STATUS, v); chk("status", v, stat(1'b0));
      r = $urandom;
      wr(otg_event_pkg::OFS_EVENT_FLAGS, r);
      expFlags &= ~r[7:0];
      rd(otg_event_pkg::OFS_EVENT_FLAGS, v); chk("flags", v, {24'h0, expFlags});
    end
    $display("test pin events done");
    // line idle since reset: timer and stable line both due near 100000
    while (cyc < 100050) @(posedge mclk);
    expFlags |= 8'h60;
    rd(otg_event_pkg::OFS_EVENT_FLAGS, v); chk("flags", v, {24'h0, expFlags});
    rd(otg_event_pkg::OFS_LIVE_STATUS, v); chk("status", v, stat(1'b1));
    chk("irq", {31'h0, otgIrq}, {31'h0, |(expFlags & expEn)});
    $display("test timer and line done");
    wrap_up();
  end
endmodule
`default_nettype wire

// [verilog/otg_event_pkg.sv]
// package for the otg event and status block: register map, bit positions,
// reset values and timing constants
// assumes a 100 MHz module clock and a simple strobe register port
package otg_event_pkg;

  // -----------------------------------------------------------------
  // register map (word byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h00;  // otg_event_flags, w1c
  localparam logic [7:0] OFS_EVENT_ENABLES = 8'h04;  // otg_event_enables, rw
  localparam logic [7:0] OFS_LIVE_STATUS   = 8'h08;  // otg_live_status, ro

  // -----------------------------------------------------------------
  // bit positions, shared by flags and enables
  // -----------------------------------------------------------------
  localparam int BIT_IDENT   = 7;  // cable ident change
  localparam int BIT_MSTIMER = 6;  // 1 ms timer
  localparam int BIT_LINE    = 5;  // line stable
  localparam int BIT_WAKE    = 4;  // wake activity
  localparam int BIT_SESSION = 3;  // session drop / session valid state
  localparam int BIT_BEND    = 2;  // b session end
  localparam int BIT_AVBUS   = 0;  // session valid change / a vbus valid state

  // implemented bits of the flag and enable registers: 7..2 and 0
  localparam logic [7:0] IMPL_MASK   = 8'hfd;
  localparam logic [7:0] STATUS_MASK = 8'had;  // live status bits 7,5,3,2,0
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ      = 100;   // module clock rate
  localparam int MS_TIME_US   = 1000;  // one millisecond in us
  localparam int MS_CYCLES    = MS_TIME_US * CLK_MHZ;  // 100000 cycles
  localparam logic [16:0] TIMER_RESET = 17'h00000;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic identPin;      // cable ident pin, high = none or type b
    logic sessValid;     // vbus above session valid (a or b)
    logic sessEnd;       // vbus below session valid on b device
    logic aVbusValid;    // vbus above session valid on a device
    logic se0;           // line single ended zero indication
    logic line_j_indication;        // line j indication
    logic dPlus;         // raw d+ level, for wake detection
    logic dMinus;        // raw d- level, for wake detection
  } pins_t;

  typedef struct packed {
    logic [7:0] addr;    // byte address
    logic [31:0] wdata;  // write data
    logic wr;            // write strobe
    logic rd;            // read strobe
  } regreq_t;

endpackage

// [verilog/usb_otg_event_status.sv]
// otg event and status logic: pin sampling, event flags, enables, status
// assumes asynchronous pins from the transceiver and comparators, and a master
// that uses one-cycle read and write strobes with read data one cycle later
`timescale 1ns/1ps
`default_nettype none

module usb_otg_event_status (
  input  wire logic                   mclk,     // 100 MHz module clock
  input  wire logic                   rst,      // async, active high
  input  wire otg_event_pkg::pins_t   pinsIn,   // asynchronous pin levels
  input  wire otg_event_pkg::regreq_t regReq,   // register port request
  output logic [31:0]                 rdata,    // read data, cycle after rd
  output logic                        otgIrq    // level interrupt
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    otg_event_pkg::pins_t sync1;     // first synchroniser stage
    otg_event_pkg::pins_t sync2;     // second synchroniser stage
    otg_event_pkg::pins_t prev;      // last sampled synchronous levels
    logic                 primed;    // prev valid after reset
    logic [7:0]           flags;     // event flags
    logic [7:0]           enables;   // enable bits
    logic [16:0]          msCount;   // free running ms timer
    logic [16:0]          lineCount; // cycles line state unchanged
    logic                 lineStable;// line state stable for 1 ms
    logic [1:0]           lineLast;  // last reported stable line state
    logic [1:0]           fill;      // reset fill chain ahead of primed
    logic                 lineSeen;  // a stable state has been reported
    logic [31:0]          rdata;     // registered read data
  } state_t;

  state_t s_q;  // registered state
  state_t s_d;  // next state

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // live status byte from synchronised levels
  function automatic logic [7:0] statusByte(input otg_event_pkg::pins_t p, input logic stable);
    logic [7:0] b;
    b = otg_event_pkg::RESET_BYTE;
    b[otg_event_pkg::BIT_IDENT]   = p.identPin;
    b[otg_event_pkg::BIT_LINE]    = stable;
    b[otg_event_pkg::BIT_SESSION] = p.sessValid;
    b[otg_event_pkg::BIT_BEND]    = p.sessEnd;
    b[otg_event_pkg::BIT_AVBUS]   = p.aVbusValid;
    return b;
  endfunction

  localparam logic [16:0] MS_LAST = 17'(otg_event_pkg::MS_CYCLES - 1);

  logic [7:0] events;     // one-cycle event pulses this cycle
  logic       msTick;     // 1 ms timer expiry
  logic [1:0] lineNow;    // current se0 / j pair
  logic       lineChange; // line pair differs from last cycle

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    events = otg_event_pkg::RESET_BYTE;
    // two-flop synchronisers; first stage read only by the second
    s_d.sync1 = pinsIn;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    // prev holds a real pin sample only from the third edge after reset:
    // sync2 is filled at the second edge and prev copies it at the third,
    // so an earlier compare would report the reset zeros as pin changes
    s_d.fill = {s_q.fill[0], 1'b1};
    s_d.primed = s_q.fill[1];

    // free running 1 ms timer
    msTick = (s_q.msCount == MS_LAST);
    s_d.msCount = msTick ? otg_event_pkg::TIMER_RESET : s_q.msCount + 17'h00001;
    events[otg_event_pkg::BIT_MSTIMER] = msTick;

    // line state stability: restart count on any change of se0 or j
    lineNow = {s_q.sync2.se0, s_q.sync2.line_j_indication};
    lineChange = s_q.primed && (lineNow != {s_q.prev.se0, s_q.prev.line_j_indication});
    if (lineChange || !s_q.primed) begin
      s_d.lineCount = otg_event_pkg::TIMER_RESET;
      s_d.lineStable = 1'b0;
    end else if (s_q.lineCount == MS_LAST) begin
      s_d.lineStable = 1'b1;
      // report only a stable state that differs from the last one
      if (!s_q.lineStable && (!s_q.lineSeen || lineNow != s_q.lineLast)) begin
        events[otg_event_pkg::BIT_LINE] = 1'b1;
      end
      if (!s_q.lineStable) begin
        s_d.lineLast = lineNow;
        s_d.lineSeen = 1'b1;
      end
    end else begin
      s_d.lineCount = s_q.lineCount + 17'h00001;
    end

    // pin change events, only once prev holds a real sample
    if (s_q.primed) begin
      events[otg_event_pkg::BIT_IDENT] = s_q.sync2.identPin != s_q.prev.identPin;
      events[otg_event_pkg::BIT_WAKE] = (s_q.sync2.dPlus != s_q.prev.dPlus)
        || (s_q.sync2.dMinus != s_q.prev.dMinus)
        || (s_q.sync2.identPin != s_q.prev.identPin)
        || (s_q.sync2.sessValid != s_q.prev.sessValid)
        || (s_q.sync2.aVbusValid != s_q.prev.aVbusValid);
      // session end level crossed downward: session end comparator rises
      events[otg_event_pkg::BIT_SESSION] = s_q.sync2.sessEnd && !s_q.prev.sessEnd;
      events[otg_event_pkg::BIT_BEND] = s_q.sync2.sessEnd != s_q.prev.sessEnd;
      events[otg_event_pkg::BIT_AVBUS] = s_q.sync2.sessValid != s_q.prev.sessValid;
    end

    // register writes
    if (regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_FLAGS) begin
      // write one clears, zero leaves alone
      s_d.flags = s_q.flags & ~regReq.wdata[7:0];
    end
    if (regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_ENABLES) begin
      s_d.enables = regReq.wdata[7:0] & otg_event_pkg::IMPL_MASK;
    end
    // set wins over a clear in the same cycle
    s_d.flags = (s_d.flags | events) & otg_event_pkg::IMPL_MASK;

    // register reads, unmapped answers zero
    s_d.rdata = 32'h00000000;
    if (regReq.rd) begin
      case (regReq.addr)
        otg_event_pkg::OFS_EVENT_FLAGS:   s_d.rdata = {24'h000000, s_q.flags};
        otg_event_pkg::OFS_EVENT_ENABLES: s_d.rdata = {24'h000000, s_q.enables};
        otg_event_pkg::OFS_LIVE_STATUS:
          s_d.rdata = {24'h000000, statusByte(s_q.sync2, s_q.lineStable)};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign rdata = s_q.rdata;
  assign otgIrq = |(s_q.flags & s_q.enables);

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  property p_irq_tracks;
    @(posedge mclk) disable iff (rst) otgIrq == |(s_q.flags & s_q.enables);
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("irq not flag and enable");

  property p_w1c;
    @(posedge mclk) disable iff (rst)
      regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_FLAGS && regReq.wdata[7] && !events[7]
      |=> !s_q.flags[7];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  property p_set_wins;
    @(posedge mclk) disable iff (rst) events[otg_event_pkg::BIT_IDENT] |=> s_q.flags[7];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("ident event lost");

  property p_sticky;
    @(posedge mclk) disable iff (rst)
      s_q.flags[5] && !(regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_FLAGS) |=> s_q.flags[5];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");

  property p_timer;
    @(posedge mclk) disable iff (rst) msTick |=> s_q.flags[6] && s_q.msCount == 17'h00000;
  endproperty
  a_timer: assert property (p_timer) else $error("timer flag missing");

  property p_reserved;
    @(posedge mclk) disable iff (rst) s_q.rdata[31:8] == 24'h000000 && !s_q.rdata[1];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_enable_rw;
    @(posedge mclk) disable iff (rst)
      regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_ENABLES
      |=> s_q.enables == ($past(regReq.wdata[7:0]) & otg_event_pkg::IMPL_MASK);
  endproperty
  a_enable_rw: assert property (p_enable_rw) else $error("enable write lost");

  property p_bend;
    @(posedge mclk) disable iff (rst)
      s_q.primed && (s_q.sync2.sessEnd != s_q.prev.sessEnd) |=> s_q.flags[2];
  endproperty
  a_bend: assert property (p_bend) else $error("session end change missed");

  property p_avbus;
    @(posedge mclk) disable iff (rst)
      s_q.primed && (s_q.sync2.sessValid != s_q.prev.sessValid) |=> s_q.flags[0] && s_q.flags[4];
  endproperty
  a_avbus: assert property (p_avbus) else $error("session valid change missed");

  property p_status_rd;
    @(posedge mclk) disable iff (rst)
      regReq.rd && regReq.addr == otg_event_pkg::OFS_LIVE_STATUS
      |=> rdata[7] == $past(s_q.sync2.identPin) && rdata[3] == $past(s_q.sync2.sessValid);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_line_unstable;
    @(posedge mclk) disable iff (rst) lineChange |=> !s_q.lineStable;
  endproperty
  a_line_unstable: assert property (p_line_unstable) else $error("line stable after change");

  // -----------------------------------------------------------------
  // further checks on the event sources and the read path
  // -----------------------------------------------------------------
  // the checks below watch the registered state one edge after the
  // combinational event pulse; a pulse and a clear in the same cycle
  // must leave the flag set, since software would otherwise lose an
  // event that it never saw
  // the read checks use $past on the synchronised levels, because the
  // status byte is built from sync2 at the edge that takes the strobe
  // note: the line stable flag fires once per new stable pair, so a
  // line that never moves reports only the first stable state

  // a new stable line state lands in the flag and in the status level
  property p_line_event;
    @(posedge mclk) disable iff (rst)
      events[otg_event_pkg::BIT_LINE] |=> s_q.flags[5] && s_q.lineStable;
  endproperty
  a_line_event: assert property (p_line_event) else $error("line flag missing");

  // raw d+ movement wakes the block
  property p_wake;
    @(posedge mclk) disable iff (rst)
      s_q.primed && (s_q.sync2.dPlus != s_q.prev.dPlus) |=> s_q.flags[4];
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag missing");

  // session end comparator rising means vbus fell below end level
  property p_drop;
    @(posedge mclk) disable iff (rst)
      s_q.primed && s_q.sync2.sessEnd && !s_q.prev.sessEnd |=> s_q.flags[3];
  endproperty
  a_drop: assert property (p_drop) else $error("session drop flag missing");

  // no pin event while prev still holds reset zeros
  property p_quiet_start;
    @(posedge mclk) disable iff (rst)
      !s_q.primed |-> (events & 8'hbf) == 8'h00;
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("pin event before priming");

  // a zero written to a set flag leaves it alone
  property p_zero_write;
    @(posedge mclk) disable iff (rst)
      regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_FLAGS && !regReq.wdata[5] && s_q.flags[5]
      |=> s_q.flags[5];
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("flag cleared by zero");

  // enables move only on a write to their own address
  property p_enable_hold;
    @(posedge mclk) disable iff (rst)
      !(regReq.wr && regReq.addr == otg_event_pkg::OFS_EVENT_ENABLES) |=> $stable(s_q.enables);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write");

  // status bit 5 mirrors the stability level
  property p_status_line;
    @(posedge mclk) disable iff (rst)
      regReq.rd && regReq.addr == otg_event_pkg::OFS_LIVE_STATUS |=> rdata[5] == $past(s_q.lineStable);
  endproperty
  a_status_line: assert property (p_status_line) else $error("status line bit wrong");

  // status bit 2 mirrors the session end comparator
  property p_status_end;
    @(posedge mclk) disable iff (rst)
      regReq.rd && regReq.addr == otg_event_pkg::OFS_LIVE_STATUS |=> rdata[2] == $past(s_q.sync2.sessEnd);
  endproperty
  a_status_end: assert property (p_status_end) else $error("status end bit wrong");

  // status bit 0 mirrors the a device vbus comparator
  property p_status_avbus;
    @(posedge mclk) disable iff (rst)
      regReq.rd && regReq.addr == otg_event_pkg::OFS_LIVE_STATUS |=> rdata[0] == $past(s_q.sync2.aVbusValid);
  endproperty
  a_status_avbus: assert property (p_status_avbus) else $error("status a vbus bit wrong");

  // read data stand one cycle only, zero otherwise
  property p_rdata_idle;
    @(posedge mclk) disable iff (rst) !regReq.rd |=> s_q.rdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  c_irq: cover property (@(posedge mclk) disable iff (rst) $rose(otgIrq));
  c_line: cover property (@(posedge mclk) disable iff (rst) events[otg_event_pkg::BIT_LINE]);
  c_clear: cover property (@(posedge mclk) disable iff (rst) s_q.flags[7] ##1 !s_q.flags[7]);
  c_timer: cover property (@(posedge mclk) disable iff (rst) msTick);
  c_drop: cover property (@(posedge mclk) disable iff (rst) events[otg_event_pkg::BIT_SESSION]);

endmodule

`default_nettype wire
